/* File: logic/xbi_external_bus.sv */
module xbi_external_bus
    import xbi_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic external_bus_clock,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic [1:0] req_size,
    input wire logic [XBI_ADDR_W-1:0] req_addr,
    input wire logic [XBI_DATA_W-1:0] req_wdata,
    input wire logic [XBI_SEL_W-1:0] req_sel,
    input wire logic req_dram,
    input wire logic req_bank,
    input wire logic req_refresh,
    output logic rsp_valid,
    output logic [XBI_DATA_W-1:0] rsp_rdata,
    output logic [XBI_ADDR_W-1:0] addr,
    input wire logic [XBI_DATA_W-1:0] data_in,
    output logic [XBI_DATA_W-1:0] data_out,
    output logic data_oe,
    output logic oe_n,
    output logic we_n,
    output logic [XBI_SEL_W-1:0] ce_cas_n,
    output logic [XBI_RAS_W-1:0] ras_n,
    input wire logic wait_n,
    output logic byte_access_n,
    input wire logic boot_width_strap,
    output logic boot_x16
);
    // all block state
    typedef struct packed
    {
        xbi_state_e st;
        logic [XBI_CNT_W-1:0] cnt;
        logic [XBI_ADDR_W-1:0] addr;
        logic [XBI_DATA_W-1:0] wdata;
        logic [XBI_DATA_W-1:0] rdata;
        logic write;
        logic byte_n;
        logic [XBI_SEL_W-1:0] sel;
        logic dram;
        logic bank;
        logic refresh;
        logic rsp;
        logic strap_done;
        logic boot16;
        logic oe_n;
        logic we_n;
        logic [XBI_SEL_W-1:0] ce_n;
        logic [XBI_RAS_W-1:0] ras_n;
        logic doe;
    } xbi_s;

    xbi_s s_q;
    xbi_s s_d;
    logic fall; // falling edge of bus clock seen
    logic wait_hit; // wait found active at that edge

    // falling edge wait sampler
    xbi_wait_sampler u_ws
    (
        .mclk(mclk),
        .reset_n(reset_n),
        .external_bus_clock(external_bus_clock),
        .wait_n(wait_n),
        .fall_pulse(fall),
        .wait_seen(wait_hit)
    );

    // sequencer and pin state
    always_comb
    begin
        s_d = s_q;
        s_d.rsp = 1'b0;
        if (!s_q.strap_done)
        begin
            s_d.strap_done = 1'b1;
            s_d.boot16 = boot_width_strap;
        end
        case (s_q.st)
            XBI_IDLE:
            begin
                s_d.oe_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.ce_n = '1;
                s_d.ras_n = '1;
                s_d.doe = 1'b0;
                if (req_valid)
                begin
                    s_d.addr = req_addr;
                    s_d.wdata = req_wdata;
                    s_d.write = req_write;
                    s_d.byte_n = (req_size != XBI_SZ_BYTE);
                    s_d.sel = req_sel;
                    s_d.dram = req_dram;
                    s_d.bank = req_bank;
                    s_d.refresh = req_refresh;
                    s_d.cnt = XBI_BASE_CYC;
                    s_d.st = XBI_SETUP;
                end
            end
            XBI_SETUP:
            begin
                s_d.oe_n = s_q.write | s_q.refresh;
                s_d.we_n = ~s_q.write | s_q.refresh;
                s_d.doe = s_q.write & ~s_q.refresh;
                if (s_q.dram | s_q.refresh)
                begin
                    s_d.ras_n[s_q.bank] = 1'b0;
                end
                s_d.ce_n = ~s_q.sel;
                s_d.st = XBI_XFER;
            end
            XBI_XFER:
            begin
                if (fall)
                begin
                    if (s_q.cnt > 4'h1)
                    begin
                        s_d.cnt = s_q.cnt - 4'h1;
                    end
                    else if (!wait_hit)
                    begin
                        s_d.st = XBI_DONE;
                        // only reads take the bus; a write keeps the last read word
                        if (!s_q.write)
                        begin
                            s_d.rdata = data_in;
                        end
                    end
                end
            end
            XBI_DONE:
            begin
                s_d.oe_n = 1'b1;
                s_d.we_n = 1'b1;
                s_d.ce_n = '1;
                s_d.ras_n = '1;
                s_d.doe = 1'b0;
                s_d.rsp = 1'b1;
                s_d.st = XBI_IDLE;
            end
            default:
            begin
                s_d.st = XBI_IDLE;
            end
        endcase
    end

    // registers; strap flag clears at reset so capture follows release
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
            s_q.st <= XBI_IDLE;
            s_q.oe_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.ce_n <= '1;
            s_q.ras_n <= '1;
            s_q.byte_n <= 1'b1;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign req_ready = (s_q.st == XBI_IDLE);
    assign rsp_valid = s_q.rsp;
    assign rsp_rdata = s_q.rdata;
    assign addr = s_q.addr;
    assign data_out = s_q.wdata;
    assign data_oe = s_q.doe;
    assign oe_n = s_q.oe_n;
    assign we_n = s_q.we_n;
    assign ce_cas_n = s_q.ce_n;
    assign ras_n = s_q.ras_n;
    assign byte_access_n = s_q.byte_n;
    assign boot_x16 = s_q.boot16;

    a_read_oe: assert property (@(posedge mclk) disable iff (!reset_n)
        (s_q.st == XBI_XFER && !s_q.write && !s_q.refresh) |-> (!oe_n && we_n))
        else $error("oe not low on read");
    a_write_we: assert property (@(posedge mclk) disable iff (!reset_n)
        (s_q.st == XBI_XFER && s_q.write && !s_q.refresh) |-> (!we_n && oe_n && data_oe))
        else $error("we not low on write");
    a_idle_strobes: assert property (@(posedge mclk) disable iff (!reset_n)
        (s_q.st == XBI_IDLE) |-> (oe_n && we_n && &ce_cas_n && &ras_n))
        else $error("strobe active while idle");
    a_wait_extend: assert property (@(posedge mclk) disable iff (!reset_n)
        (s_q.st == XBI_XFER && fall && wait_hit && s_q.cnt == 4'h1) |=> (s_q.st == XBI_XFER))
        else $error("wait did not extend");
    a_wait_done: assert property (@(posedge mclk) disable iff (!reset_n)
        (s_q.st == XBI_XFER && fall && !wait_hit && s_q.cnt == 4'h1) |=> ##1 rsp_valid)
        else $error("transfer not finished");
    a_byte_flag: assert property (@(posedge mclk) disable iff (!reset_n)
        (req_ready && req_valid) |=> (byte_access_n == $past(req_size != XBI_SZ_BYTE)))
        else $error("byte flag wrong");
    a_ras_bank: assert property (@(posedge mclk) disable iff (!reset_n)
        (s_q.st == XBI_XFER && s_q.dram) |-> (ras_n[s_q.bank] == 1'b0 && ras_n[~s_q.bank]))
        else $error("wrong row strobe");
    a_strap_hold: assert property (@(posedge mclk) disable iff (!reset_n)
        $past(s_q.strap_done) |-> $stable(boot_x16))
        else $error("strap changed after capture");
endmodule : xbi_external_bus

/* File: logic/xbi_pkg.sv */
package xbi_pkg;
    // widths of the external bus
    localparam int XBI_ADDR_W = 26;
    localparam int XBI_DATA_W = 16;
    localparam int XBI_SEL_W = 6;
    localparam int XBI_RAS_W = 2;
    localparam int XBI_CNT_W = 4;
    // base transfer length in external bus clock periods
    localparam logic [3:0] XBI_BASE_CYC = 4'h2;
    // command access sizes
    localparam logic [1:0] XBI_SZ_BYTE = 2'h0;
    localparam logic [1:0] XBI_SZ_WORD = 2'h1;
    localparam logic [1:0] XBI_SZ_FETCH = 2'h2;
    // bus sequencer states
    typedef enum logic [1:0]
    {
        XBI_IDLE = 2'b00,
        XBI_SETUP = 2'b01,
        XBI_XFER = 2'b10,
        XBI_DONE = 2'b11
    } xbi_state_e;
endpackage : xbi_pkg

/* File: logic/xbi_wait_sampler.sv */
// samples the wait input on each falling edge of the external bus clock
module xbi_wait_sampler
    import xbi_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic external_bus_clock,
    input wire logic wait_n,
    output logic fall_pulse,
    output logic wait_seen
);
    // held state
    typedef struct packed
    {
        logic clk_prev;
        logic wait_hit;
        logic fall;
    } xbi_ws_s;

    xbi_ws_s s_q;
    xbi_ws_s s_d;

    // detect high to low of the bus clock and grab wait at that point
    always_comb
    begin
        s_d = s_q;
        s_d.clk_prev = external_bus_clock;
        s_d.fall = s_q.clk_prev & ~external_bus_clock;
        if (s_q.clk_prev & ~external_bus_clock)
        begin
            s_d.wait_hit = ~wait_n;
        end
    end

    // registers
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_q <= '0;
        end
        else
        begin
            s_q <= s_d;
        end
    end

    assign fall_pulse = s_q.fall;
    assign wait_seen = s_q.wait_hit;
endmodule : xbi_wait_sampler

/* File: bench/xbi_mem_model.sv */
// far-side memory: small word store, slow mode stretches transfers
module xbi_mem_model
    import xbi_pkg::*;
(
    input wire logic mclk,
    input wire logic oe_n,
    input wire logic we_n,
    input wire logic [XBI_SEL_W-1:0] ce_cas_n,
    input wire logic [XBI_ADDR_W-1:0] addr,
    input wire logic [XBI_DATA_W-1:0] data_out,
    input wire logic data_oe,
    input wire logic slow,
    output logic [XBI_DATA_W-1:0] data_in,
    output logic wait_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [XBI_DATA_W-1:0] mem [16];
    // last word the part drove, shown inverted while released so no stale data survives
    logic [XBI_DATA_W-1:0] last = '0;
    wire sel_on = (ce_cas_n != 6'h3F);
    wire rd_on = !oe_n && sel_on;
    // store what the device drives, remember what the part drove
    always @(posedge mclk)
    begin
        if (!we_n && data_oe && sel_on)
            mem[addr[3:0]] <= data_out;
        if (rd_on)
            last <= mem[addr[3:0]];
    end
    // drive only while selected for a read
    assign data_in = rd_on ? mem[addr[3:0]] : ~last;
    // wait held before every sample point while slow
    assign wait_n = !(slow && sel_on);
endmodule : xbi_mem_model

/* File: bench/tb_top.sv */
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import xbi_pkg::*;
    typedef struct {logic w; logic [1:0] s; logic [25:0] a; logic [15:0] d;
        logic dr; logic bk; logic [5:0] sl;} xbi_row_s;
    // writes then read-backs, all sizes, both banks
    xbi_row_s rows [6] = '{
        '{1'b1, XBI_SZ_WORD, 26'h3FFFFF1, 16'hA55A, 1'b0, 1'b0, 6'h01},
        '{1'b1, XBI_SZ_BYTE, 26'h0000002, 16'h00C3, 1'b0, 1'b0, 6'h02},
        '{1'b0, XBI_SZ_WORD, 26'h3FFFFF1, 16'hA55A, 1'b0, 1'b0, 6'h01},
        '{1'b0, XBI_SZ_FETCH, 26'h0000002, 16'h00C3, 1'b1, 1'b1, 6'h04},
        '{1'b1, XBI_SZ_WORD, 26'h0000003, 16'h1234, 1'b1, 1'b0, 6'h20},
        '{1'b0, XBI_SZ_BYTE, 26'h0000003, 16'h1234, 1'b1, 1'b0, 6'h20}};
    xbi_row_s cur;
    logic mclk, reset_n, bus_clk, vld, slow, rf, strap, rdy, rv;
    logic doe, oe_n, we_n, byte_n, bx, wait_n;
    logic [15:0] rdat, din, dout, rd;
    logic [25:0] ad;
    logic [5:0] ce;
    logic [1:0] ras;
    int fails, tests_run, cyc;
    xbi_external_bus u_dut (.mclk(mclk), .reset_n(reset_n), .external_bus_clock(bus_clk),
        .req_valid(vld), .req_ready(rdy), .req_write(cur.w), .req_size(cur.s),
        .req_addr(cur.a), .req_wdata(cur.d), .req_sel(cur.sl), .req_dram(cur.dr),
        .req_bank(cur.bk), .req_refresh(rf), .rsp_valid(rv), .rsp_rdata(rdat),
        .addr(ad), .data_in(din), .data_out(dout), .data_oe(doe), .oe_n(oe_n),
        .we_n(we_n), .ce_cas_n(ce), .ras_n(ras), .wait_n(wait_n), .byte_access_n(byte_n),
        .boot_width_strap(strap), .boot_x16(bx));
    xbi_mem_model u_mem (.mclk(mclk), .oe_n(oe_n), .we_n(we_n), .ce_cas_n(ce), .addr(ad),
        .data_out(dout), .data_oe(doe), .slow(slow), .data_in(din), .wait_n(wait_n));
    // compare and count
    task chk(string n, logic [31:0] e, logic [31:0] g);
        tests_run++;
        if (e !== g)
        begin
            $display("unexpected %s exp %h got %h", n, e, g);
            fails++;
        end
    endtask : chk
    task results;
        if (fails == 0 && tests_run > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : results
    // one transfer, pins checked each cycle while strobes are active
    task xfer(xbi_row_s r);
        @(negedge mclk);
        cur = r;
        vld = 1'b1;
        chk("ready", 1, rdy);
        @(negedge mclk);
        vld = 1'b0;
        for (cyc = 0; cyc < 200 && rv !== 1'b1; cyc++)
        begin
            @(negedge mclk);
            if (oe_n === 1'b0 || we_n === 1'b0 || ras !== 2'h3)
            begin
                chk("oe_n", r.w | rf, oe_n);
                chk("we_n", !r.w | rf, we_n);
                chk("addr", r.a, ad);
                chk("doe", r.w & !rf, doe);
                chk("ce", 6'h3F, ce ^ r.sl);
                chk("ras", (r.dr | rf) ? (r.bk ? 2'h1 : 2'h2) : 2'h3, ras);
                // byte flag carries no meaning during refresh
                if (!rf)
                    chk("byte_access_n", r.s != XBI_SZ_BYTE, byte_n);
                if (r.w && !rf)
                    chk("dout", r.d, dout);
            end
        end
        if (cyc == 200)
        begin
            fails++;
            results;
        end
        rd = rdat;
        chk("idle", 10'h3FF, {ce, ras, oe_n, we_n});
    endtask : xfer
    initial
    begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    // bus clock of four mclk periods, edges on mclk falls
    initial
    begin
        bus_clk = 1'b0;
        forever #50 bus_clk = ~bus_clk;
    end
    initial
    begin
        {vld, slow, rf, reset_n} = '0;
        strap = 1'b1;
        cur = rows[0];
        repeat (10) @(negedge mclk);
        chk("rst", 10'h3FF, {ce, ras, oe_n, we_n});
        reset_n = 1'b1;
        repeat (2) @(negedge mclk);
        strap = 1'b0;
        repeat (2) @(negedge mclk);
        chk("boot_x16", 1, bx);
        foreach (rows[i])
        begin
            xfer(rows[i]);
            if (!rows[i].w)
                chk("rdata", rows[i].d, rd);
        end
        // refresh over a written word: row strobe and ce_cas_n only, no write may land
        rf = 1'b1;
        xfer(xbi_row_s'{1'b1, XBI_SZ_WORD, 26'h0000003, 16'h5AA5, 1'b1, 1'b0, 6'h20});
        rf = 1'b0;
        xfer(rows[5]);
        chk("refresh_kept", rows[5].d, rd);
        // slow part: wait held 20 cycles, then released
        slow = 1'b1;
        fork
            xfer(rows[2]);
            begin
                repeat (20) @(negedge mclk);
                slow = 1'b0;
            end
        join
        chk("waitlong", 1, cyc > 18);
        chk("waitend", 1, cyc < 40);
        chk("wdata", 16'hA55A, rd);
        reset_n = 1'b0;
        repeat (10) @(negedge mclk);
        reset_n = 1'b1;
        repeat (3) @(negedge mclk);
        chk("boot_x8", 0, bx);
        results;
    end
endmodule : tb_top
